/* core/isa_host.sv */
// Bus master end: sends start, bytes and stop on command, reads ack back
`timescale 1ns/1ps
`include "isa_regs.svh"
module isa_host (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Command port
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  wire logic [7:0] cmd_byte,
	input  wire logic       cmd_stop,
	output logic            done_pulse,
	output logic            ack_seen_q,
	// Link
	isa_if.host             bus
);
	// ==========================================================
	// State
	isa_pkg::isa_host_state_t st_q;
	logic [7:0]  sh_q;             // Byte being sent
	logic [3:0]  bit_q;            // Bit index, 8 is the ack slot
	logic [7:0]  cnt_q;            // Half period timer
	logic        stop_q;           // Stop after this byte
	logic        started_q;        // Start already sent
	logic        scl_s1_q;
	logic        scl_s2_q;         // Synchronised clock line
	logic        sda_s1_q;
	logic        sda_s2_q;
	logic        tick;
	// Two flops on the lines, they come from outside the clock domain
	always_ff @(posedge clk) begin
		scl_s1_q <= bus.scl;
		scl_s2_q <= scl_s1_q;
		sda_s1_q <= bus.sda;
		sda_s2_q <= sda_s1_q;
	end
	// Half period timer; paused while our clock is released but the line stays low,
	// so a stretch by the slave also holds back the stop condition
	always_ff @(posedge clk) begin
		if (rst || tick) begin
			cnt_q <= 8'h00;
		end else if (!((st_q == isa_pkg::H_BIT_HI || st_q == isa_pkg::H_STOP_HI) &&
			bus.scl_o_m && !scl_s2_q)) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end
	assign tick = (cnt_q == 8'(`ISA_HALF_CYC - 1));
	assign cmd_ready = (st_q == isa_pkg::H_IDLE) ||
		(st_q == isa_pkg::H_BIT_LO && bit_q == 4'h9 && !bus.scl_o_m);
	assign bus.scl_oe_m = 1'b1;
	assign bus.sda_oe_m = 1'b1;
	// Sequencer drives both lines from flops
	always_ff @(posedge clk) begin
		done_pulse <= 1'b0;
		if (rst) begin
			st_q <= isa_pkg::H_IDLE;
			bus.scl_o_m <= 1'b1;
			bus.sda_o_m <= 1'b1;
			sh_q <= 8'h00;
			bit_q <= 4'h0;
			stop_q <= 1'b0;
			started_q <= 1'b0;
			ack_seen_q <= 1'b0;
		end else begin
			case (st_q)
				isa_pkg::H_IDLE: begin
					if (cmd_valid) begin
						sh_q <= cmd_byte;
						stop_q <= cmd_stop;
						bit_q <= 4'h0;
						st_q <= isa_pkg::H_START;
					end
				end
				isa_pkg::H_START: begin
					// Data falls while clock high: start, entered only from idle
					if (tick) begin
						bus.sda_o_m <= 1'b0;
						started_q <= 1'b1;
						st_q <= isa_pkg::H_BIT_LO;
					end
				end
				isa_pkg::H_BIT_LO: begin
					if (bit_q == 4'h9) begin
						// Ninth clock falls before waiting, so the slave ends its ack
						// and raises its flags while we wait for the next order
						if (bus.scl_o_m) begin
							if (tick) begin
								bus.scl_o_m <= 1'b0;
							end
						end else if (cmd_valid) begin
							sh_q <= cmd_byte;
							stop_q <= cmd_stop;
							bit_q <= 4'h0;
						end else if (stop_q) begin
							st_q <= isa_pkg::H_STOP_LO;
						end
					end else if (tick) begin
						bus.scl_o_m <= 1'b0;
						bus.sda_o_m <= (bit_q == 4'h8) ? 1'b1 : sh_q[7];
						st_q <= isa_pkg::H_BIT_HI;
					end
				end
				isa_pkg::H_BIT_HI: begin
					if (tick) begin
						bus.scl_o_m <= 1'b1;
					end
					if (tick && scl_o_m_hi()) begin
						if (bit_q == 4'h8) begin
							ack_seen_q <= ~sda_s2_q;
							done_pulse <= 1'b1;
						end
						sh_q <= {sh_q[6:0], 1'b0};
						bit_q <= bit_q + 4'h1;
						st_q <= isa_pkg::H_BIT_LO;
					end
				end
				isa_pkg::H_STOP_LO: begin
					if (tick) begin
						bus.scl_o_m <= 1'b0;
						bus.sda_o_m <= 1'b0;
						st_q <= isa_pkg::H_STOP_HI;
					end
				end
				isa_pkg::H_STOP_HI: begin
					// Clock up, then data up: stop
					if (tick) begin
						if (!bus.scl_o_m) begin
							bus.scl_o_m <= 1'b1;
						end else begin
							bus.sda_o_m <= 1'b1;
							started_q <= 1'b0;
							st_q <= isa_pkg::H_IDLE;
						end
					end
				end
				default: st_q <= isa_pkg::H_IDLE;
			endcase
		end
	end
	// True from the cycle after our clock output has been released high
	function automatic logic scl_o_m_hi();
		return bus.scl_o_m;
	endfunction
endmodule

/* core/isa_if.sv */
// Two-wire link between bus master and slave port, open drain resolved here
`timescale 1ns/1ps
interface isa_if;
	// Clock line drives
	logic scl_o_m;
	logic scl_oe_m;
	logic scl_o_s;
	logic scl_oe_s;
	// Data line drives
	logic sda_o_m;
	logic sda_oe_m;
	logic sda_o_s;
	logic sda_oe_s;
	// Resolved lines, pulled up when nobody drives low
	logic scl;
	logic sda;
	assign scl = ~((scl_oe_m & ~scl_o_m) | (scl_oe_s & ~scl_o_s));
	assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_s & ~sda_o_s));
	// Slave port end
	modport dev (input scl, input sda, output scl_o_s, output scl_oe_s,
		output sda_o_s, output sda_oe_s);
	// Bus master end
	modport host (input scl, input sda, output scl_o_m, output scl_oe_m,
		output sda_o_m, output sda_oe_m);
endinterface

/* core/isa_pkg.sv */
// Types shared by both ends of the two-wire slave port
package isa_pkg;
	// Slave byte sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_ACK,
		ST_HOLD,
		ST_SEND,
		ST_SKIP
	} isa_state_t;
	// Host link sequencer states
	typedef enum logic [2:0] {
		H_IDLE,
		H_START,
		H_BIT_LO,
		H_BIT_HI,
		H_STOP_LO,
		H_STOP_HI
	} isa_host_state_t;
endpackage

/* core/isa_regs.svh */
// Register offsets, field positions, reset values and timing counts of the two-wire slave port
`ifndef ISA_REGS_SVH
`define ISA_REGS_SVH
// ==========================================================
// Register byte offsets (APB, one aligned word each)
`define ISA_OFF_CTRL1    12'h000
`define ISA_OFF_CTRL2    12'h004
`define ISA_OFF_STATUS   12'h008
`define ISA_OFF_ADDR     12'h00C
`define ISA_OFF_BUF      12'h010
// ==========================================================
// Control one fields
`define ISA_C1_OV        6
`define ISA_C1_EN        5
`define ISA_C1_CKP       4
// Control two fields
`define ISA_C2_GENERAL_CALL_ENABLE      7
`define ISA_C2_SEN       0
// Status fields
`define ISA_ST_DA        5
`define ISA_ST_P         4
`define ISA_ST_S         3
`define ISA_ST_RW        2
`define ISA_ST_UA        1
`define ISA_ST_BF        0
`define ISA_ST_IF        7
// ==========================================================
// Mode codes
`define ISA_MODE_S7      4'h6
`define ISA_MODE_S10     4'h7
`define ISA_MODE_S7SP    4'hE
`define ISA_MODE_S10SP   4'hF
// Reset values
`define ISA_RST_CTRL1    8'h00
`define ISA_RST_CTRL2    8'h00
`define ISA_RST_ADDR     8'h00
// Host bus clock half period in ns and derived 40 MHz cycles
`define ISA_HALF_NS      2500
`define ISA_CLK_NS       25
`define ISA_HALF_CYC     (`ISA_HALF_NS / `ISA_CLK_NS)
`endif

/* core/isa_slave.sv */
// Slave end: APB register file, address match, receive, ack and clock stretch
// Operation
// (R1) General call interrupts only when enabled
// (R2) 7-bit mask bits make address bits don't-care
// (R3) 10-bit low mask bit masks two bits
// (R4) Top two 10-bit address bits never masked
// (R5) Ack every address matching unmasked bits
// (R6) Stretch enable stretches clock after receives
// (R7) Software sets no stretch enable while active
// (R8) Four-bit mode field selects slave type
// (R9) Codes 0110,0111,1110,1111 are slave modes
// (R10) Enable makes lines open-drain outputs
// (R11) Interrupt on match; optional start/stop interrupts
// (R12) Match or data: ack and load buffer
// (R13) Full or overflow: no ack, no load
// (R14) Buffer read clears full; overflow by software
// (R15) Shift 8 bits on rise, compare after eighth
// (R16) Match loads buffer, sets full, flag on ninth
// (R17) Master sends 11110 prefix first for 10-bit
// (R18) 10-bit address byte sets update-address, holds clock
// (R19) Software reloads address halves and reads buffer
// (R20) Repeated-start high byte sets no update-address
// (R21) Write match clears direction, loads, acks
// (R22) Flag every byte; software clears it
// (R23) Stretch after data until clock-release set
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "isa_regs.svh"
module isa_slave (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Port interrupt flag level
	output logic             irq_flag,
	// Link
	isa_if.dev               bus
);
	// ==========================================================
	// Registers
	logic [7:0] ctrl1_q;          // Overflow, enable, release, mode
	logic [7:0] ctrl2_q;          // Gcall, mask field, stretch enable
	logic [7:0] addr_q;           // Own address
	logic [7:0] buf_q;            // Receive buffer
	logic [7:0] sr_q;             // Shift register
	logic       bf_q, ua_q, rw_q, da_q, s_q, p_q, if_q;
	logic       ack_q;            // Driving ack low
	logic       stretch_q;        // Holding clock low
	logic       hi_ok_q;          // 10-bit high byte seen
	logic       second_q;         // Next address byte is 10-bit low byte
	logic       addr_ph_q;        // Current byte is an address byte
	logic [3:0] cnt_q;            // Bits shifted
	isa_pkg::isa_state_t st_q;
	logic scl1_q, scl2_q, scl3_q, sda1_q, sda2_q, sda3_q;
	// ==========================================================
	// Line synchronisers; edges are found on the second and third flops
	always_ff @(posedge clk) begin
		scl1_q <= bus.scl;
		scl2_q <= scl1_q;
		scl3_q <= scl2_q;
		sda1_q <= bus.sda;
		sda2_q <= sda1_q;
		sda3_q <= sda2_q;
	end
	logic rise, fall, start_c, stop_c, en, wr, rd, ten, spi;
	assign rise = scl2_q & ~scl3_q;
	assign fall = ~scl2_q & scl3_q;
	assign start_c = scl2_q & scl3_q & ~sda2_q & sda3_q;
	assign stop_c = scl2_q & scl3_q & sda2_q & ~sda3_q;
	// Mode decode: only the four slave codes run the slave logic
	assign en = ctrl1_q[`ISA_C1_EN] && (ctrl1_q[3:0] == `ISA_MODE_S7 ||
		ctrl1_q[3:0] == `ISA_MODE_S10 || ctrl1_q[3:0] == `ISA_MODE_S7SP ||
		ctrl1_q[3:0] == `ISA_MODE_S10SP); // (R8) (R9)
	assign ten = ctrl1_q[0];
	assign spi = ctrl1_q[3];
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	// Masked compare; upper two 10-bit bits compared exactly elsewhere
	function automatic logic amatch(input logic [7:0] a, input logic [7:0] own,
		input logic [4:0] m, input logic t);
		logic [7:0] dc;
		dc = {2'b00, m[4:1], m[0], t & m[0]}; // (R2) (R3)
		return ((a ^ own) & ~dc & {7'h7F, t}) == 8'h00; // (R5)
	endfunction
	// ==========================================================
	// Address decision on the eighth falling edge
	logic gc, hi_byte, m7, m10lo, hit;
	assign gc = (sr_q == 8'h00) && ctrl2_q[`ISA_C2_GENERAL_CALL_ENABLE]; // (R1)
	assign hi_byte = sr_q[7:3] == 5'b11110 && sr_q[2:1] == addr_q[2:1]; // (R4)
	assign m7 = amatch({sr_q[7:1], 1'b0}, {addr_q[7:1], 1'b0}, ctrl2_q[5:1], 1'b0);
	assign m10lo = amatch(sr_q, addr_q, ctrl2_q[5:1], 1'b1);
	assign hit = gc || (!ten ? m7 : (second_q ? m10lo : hi_byte));
	// ==========================================================
	// Byte sequencer: shift, ack, stretch
	always_ff @(posedge clk) begin
		if (rst || !en) begin
			st_q <= isa_pkg::ST_IDLE;
			sr_q <= 8'h00;
			cnt_q <= 4'h0;
			ack_q <= 1'b0;
			stretch_q <= 1'b0;
			addr_ph_q <= 1'b0;
			second_q <= 1'b0;
			hi_ok_q <= 1'b0;
		end else if (start_c) begin
			st_q <= isa_pkg::ST_SHIFT; // (R15)
			cnt_q <= 4'h0;
			addr_ph_q <= 1'b1;
			ack_q <= 1'b0;
			second_q <= 1'b0;
		end else if (stop_c) begin
			st_q <= isa_pkg::ST_IDLE;
			ack_q <= 1'b0;
			hi_ok_q <= 1'b0;
		end else begin
			case (st_q)
				isa_pkg::ST_SHIFT: begin
					if (rise) begin
						sr_q <= {sr_q[6:0], sda2_q}; // (R15)
						cnt_q <= cnt_q + 4'h1;
					end else if (fall && cnt_q == 4'h8) begin
						if (addr_ph_q && !hit) begin
							st_q <= isa_pkg::ST_SKIP;
						end else begin
							// Ack only when buffer free and no overflow
							ack_q <= !bf_q && !ctrl1_q[`ISA_C1_OV]; // (R12) (R13)
							st_q <= isa_pkg::ST_ACK;
						end
					end
				end
				isa_pkg::ST_ACK: begin
					if (fall) begin
						ack_q <= 1'b0;
						cnt_q <= 4'h0;
						// 10-bit address bytes other than a high byte with the read bit, and stretched data bytes, hold clock
						if (addr_ph_q && ten && (second_q || !sr_q[0])) begin
							stretch_q <= 1'b1; // (R18)
							hi_ok_q <= 1'b1;
							second_q <= !second_q && !hi_ok_q;
							addr_ph_q <= !second_q && !hi_ok_q;
						end else begin
							// Buffer counts as full once this byte lands in it
							stretch_q <= !addr_ph_q && ctrl2_q[`ISA_C2_SEN] &&
								(bf_q || ack_q); // (R6) (R23)
							addr_ph_q <= 1'b0;
						end
						st_q <= isa_pkg::ST_SHIFT;
					end
				end
				isa_pkg::ST_SKIP: begin
					st_q <= isa_pkg::ST_SKIP;
				end
				default: st_q <= isa_pkg::ST_IDLE;
			endcase
			// Release on address rewrite or clock-release bit
			if (stretch_q && ((wr && paddr == `ISA_OFF_ADDR) ||
				(wr && paddr == `ISA_OFF_CTRL1 && pwdata[`ISA_C1_CKP]))) begin
				stretch_q <= 1'b0; // (R18) (R23)
			end
		end
	end
	// Open drain: only ever pull low while enabled
	assign bus.sda_o_s = 1'b0;
	assign bus.scl_o_s = 1'b0;
	assign bus.sda_oe_s = en & ack_q; // (R10) (R21)
	assign bus.scl_oe_s = en & stretch_q & ~scl2_q; // (R10)
	// ==========================================================
	// Status flags; hardware set wins over software clear
	logic ev_byte, ev_load;
	assign ev_byte = st_q == isa_pkg::ST_ACK && fall && en; // (R16) (R22)
	assign ev_load = ev_byte && ack_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			bf_q <= 1'b0; ua_q <= 1'b0; rw_q <= 1'b0; da_q <= 1'b0;
			s_q <= 1'b0; p_q <= 1'b0; if_q <= 1'b0; buf_q <= 8'h00;
		end else begin
			if (ev_load) begin
				buf_q <= sr_q; // (R12) (R16)
				bf_q <= 1'b1;
			end else if (rd && paddr == `ISA_OFF_BUF) begin
				bf_q <= 1'b0; // (R14)
			end
			if (ev_byte && addr_ph_q) begin
				// The low 10-bit byte carries address bit 0, not a direction
				rw_q <= (ten && second_q) ? rw_q : sr_q[0]; // (R21)
				// Repeated-start read of the high byte leaves update-address clear
				if (ten && (second_q || !sr_q[0])) begin
					ua_q <= 1'b1; // (R18) (R20)
				end
			end else if (wr && paddr == `ISA_OFF_ADDR) begin
				ua_q <= 1'b0; // (R18)
			end
			if (ev_byte) begin
				da_q <= !addr_ph_q;
			end
			if (start_c) begin
				s_q <= 1'b1;
				p_q <= 1'b0;
			end else if (stop_c) begin
				p_q <= 1'b1;
				s_q <= 1'b0;
			end
			if (ev_byte || (spi && en && (start_c || stop_c))) begin
				if_q <= 1'b1; // (R11) (R13) (R22)
			end else if (wr && paddr == `ISA_OFF_STATUS && !pwdata[`ISA_ST_IF]) begin
				if_q <= 1'b0;
			end
		end
	end
	assign irq_flag = if_q;
	// ==========================================================
	// Register writes; overflow set on a refused data byte beats software clear
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl1_q <= `ISA_RST_CTRL1;
			ctrl2_q <= `ISA_RST_CTRL2;
			addr_q <= `ISA_RST_ADDR;
		end else begin
			if (wr && paddr == `ISA_OFF_CTRL1) begin
				ctrl1_q <= pwdata[7:0];
			end
			if (ev_byte && !ack_q && !addr_ph_q) begin
				ctrl1_q[`ISA_C1_OV] <= 1'b1; // (R13) (R14)
			end
			// Stretch enable may not be raised mid transfer
			if (wr && paddr == `ISA_OFF_CTRL2) begin
				ctrl2_q <= {pwdata[7], 1'b0, pwdata[5:1],
					(st_q == isa_pkg::ST_IDLE) ? pwdata[0] : ctrl2_q[0]}; // (R7)
			end
			if (wr && paddr == `ISA_OFF_ADDR) begin
				addr_q <= pwdata[7:0];
			end
		end
	end
	// Read mux, unmapped reads zero
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			case (paddr)
				`ISA_OFF_CTRL1: prdata <= {24'h000000, ctrl1_q};
				`ISA_OFF_CTRL2: prdata <= {24'h000000, ctrl2_q};
				`ISA_OFF_STATUS: prdata <= {24'h000000, if_q, 1'b0, da_q, p_q, s_q,
					rw_q, ua_q, bf_q};
				`ISA_OFF_ADDR: prdata <= {24'h000000, addr_q};
				`ISA_OFF_BUF: prdata <= {24'h000000, buf_q};
				default: prdata <= 32'h00000000;
			endcase
		end
	end
endmodule

/* tb/i2c_slave_address_receive_tb_top.sv */
// Bench joining bus master and slave port over the two-wire link
`timescale 1ns/1ps
`include "isa_regs.svh"
module i2c_slave_address_receive_tb_top;
	// ==========================================
	// Signals
	logic        clk = 1'h0;      // 40 MHz
	logic        rst = 1'h1;      // Held two cycles
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        irq_flag;
	logic        cmd_valid = 1'h0;
	logic        cmd_ready;
	logic [7:0]  cmd_byte = 8'h00;
	logic        cmd_stop = 1'h0;
	logic        done_pulse;
	logic        ack_seen_q;
	logic [31:0] rdat;            // Last APB read
	int          err_total = 0;
	int          n_checks = 0;
	int          cyc = 0;
	// Table rows: mode, control two, address byte, ack, flag
	logic [39:0] tbl [7] = '{40'h0602A20101, 40'h0602A40000, 40'h060EAE0101,
		40'h0600000000, 40'h0680000101, 40'h0E005A0001, 40'h0600A00101};
	// ==========================================
	// Design
	isa_if isa_if_i ();
	isa_slave isa_slave_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(), .irq_flag(irq_flag), .bus(isa_if_i));
	isa_host isa_host_i (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_byte(cmd_byte), .cmd_stop(cmd_stop),
		.done_pulse(done_pulse), .ack_seen_q(ack_seen_q), .bus(isa_if_i));
	isa_sva isa_sva_i (.clk(clk), .rst(rst), .scl(isa_if_i.scl), .sda(isa_if_i.sda),
		.scl_o_s(isa_if_i.scl_o_s), .scl_oe_s(isa_if_i.scl_oe_s),
		.sda_o_s(isa_if_i.sda_o_s), .sda_oe_s(isa_if_i.sda_oe_s));
	// Clock
	always #12.5 clk = ~clk;
	// Hang guard, well past the roughly 51k cycles of the tests
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			err_total++;
			end_sim;
		end
	end
	// ==========================================
	// Helpers
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t byte %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t bit %b expected %b", $time, g, e);
		end
	endtask
	// One APB transfer; request held until pready seen with penable
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rdat = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// One byte from the master; flags land a half period after the ack,
	// a stop needs three more half periods
	task automatic snd(input logic [7:0] b, input logic s, input logic ak);
		@(posedge clk);
		cmd_valid <= 1'h1;
		cmd_byte <= b;
		cmd_stop <= s;
		do @(posedge clk); while (cmd_ready !== 1'h1);
		cmd_valid <= 1'h0;
		do @(posedge clk); while (done_pulse !== 1'h1);
		repeat (s ? 500 : 150) @(posedge clk);
		chk1(ack_seen_q, ak);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset;
		chk1(isa_if_i.scl, 1'h1);
		chk1(isa_if_i.sda, 1'h1);
		apb(1'h0, `ISA_OFF_CTRL1, 32'h0);
		chk8(rdat[7:0], `ISA_RST_CTRL1);
		apb(1'h0, `ISA_OFF_CTRL2, 32'h0);
		chk8(rdat[7:0], `ISA_RST_CTRL2);
		apb(1'h0, 12'h020, 32'h0);
		chk8(rdat[7:0], 8'h00);
		$display("reset test done");
	endtask
	task automatic t_table;
		apb(1'h1, `ISA_OFF_ADDR, 32'hA0);
		foreach (tbl[i]) begin
			apb(1'h1, `ISA_OFF_CTRL1, 32'h20 | tbl[i][39:32]);
			apb(1'h1, `ISA_OFF_CTRL2, {24'h0, tbl[i][31:24]});
			snd(tbl[i][23:16], 1'h1, tbl[i][8]);
			chk1(irq_flag, tbl[i][0]);
			apb(1'h0, `ISA_OFF_BUF, 32'h0);
			if (tbl[i][8]) begin
				chk8(rdat[7:0], tbl[i][23:16]);
			end
			apb(1'h1, `ISA_OFF_STATUS, 32'h0);
		end
		$display("address table test done");
	endtask
	task automatic t_recv;
		apb(1'h1, `ISA_OFF_CTRL1, 32'h26);
		apb(1'h1, `ISA_OFF_CTRL2, 32'h0);
		snd(8'hA0, 1'h0, 1'h1);
		apb(1'h0, `ISA_OFF_STATUS, 32'h0);
		chk8(rdat[7:0] & 8'h87, 8'h81);
		apb(1'h0, `ISA_OFF_BUF, 32'h0);
		chk8(rdat[7:0], 8'hA0);
		apb(1'h0, `ISA_OFF_STATUS, 32'h0);
		chk1(rdat[0], 1'h0);
		apb(1'h1, `ISA_OFF_STATUS, 32'h0);
		snd(8'h3C, 1'h0, 1'h1);
		chk1(irq_flag, 1'h1);
		snd(8'hC3, 1'h1, 1'h0);
		apb(1'h0, `ISA_OFF_CTRL1, 32'h0);
		chk1(rdat[6], 1'h1);
		apb(1'h0, `ISA_OFF_BUF, 32'h0);
		chk8(rdat[7:0], 8'h3C);
		apb(1'h0, `ISA_OFF_CTRL1, 32'h0);
		chk1(rdat[6], 1'h1);
		apb(1'h1, `ISA_OFF_CTRL1, 32'h26);
		apb(1'h0, `ISA_OFF_CTRL1, 32'h0);
		chk1(rdat[6], 1'h0);
		apb(1'h1, `ISA_OFF_STATUS, 32'h0);
		$display("receive test done");
	endtask
	task automatic t_stretch;
		int k;
		apb(1'h1, `ISA_OFF_CTRL2, 32'h1);
		snd(8'hA0, 1'h0, 1'h1);
		apb(1'h0, `ISA_OFF_BUF, 32'h0);
		apb(1'h1, `ISA_OFF_STATUS, 32'h0);
		snd(8'h55, 1'h1, 1'h1);
		repeat (200) @(posedge clk);
		chk1(isa_if_i.scl, 1'h0);
		apb(1'h1, `ISA_OFF_CTRL1, 32'h36);
		k = 0;
		while (isa_if_i.scl !== 1'h1 && k < 50) begin
			@(posedge clk);
			k++;
		end
		chk1(isa_if_i.scl, 1'h1);
		apb(1'h0, `ISA_OFF_BUF, 32'h0);
		chk8(rdat[7:0], 8'h55);
		repeat (400) @(posedge clk);
		$display("stretch test done");
	endtask
	// Ten-bit receive: high byte 11110 01 0, low byte 5B with bits 2:0 masked
	task automatic t_ten;
		apb(1'h1, `ISA_OFF_CTRL1, 32'h27);
		apb(1'h1, `ISA_OFF_CTRL2, 32'h06);
		apb(1'h1, `ISA_OFF_ADDR, 32'hF2);
		snd(8'hF6, 1'h1, 1'h0);
		snd(8'hF2, 1'h0, 1'h1);
		apb(1'h0, `ISA_OFF_STATUS, 32'h0);
		chk8(rdat[7:0] & 8'h87, 8'h83);
		apb(1'h1, `ISA_OFF_ADDR, 32'h5B);
		apb(1'h0, `ISA_OFF_STATUS, 32'h0);
		chk1(rdat[1], 1'h0);
		apb(1'h0, `ISA_OFF_BUF, 32'h0);
		chk8(rdat[7:0], 8'hF2);
		apb(1'h1, `ISA_OFF_STATUS, 32'h0);
		snd(8'h59, 1'h0, 1'h1);
		apb(1'h0, `ISA_OFF_STATUS, 32'h0);
		chk8(rdat[7:0] & 8'h87, 8'h83);
		apb(1'h1, `ISA_OFF_ADDR, 32'hF2);
		apb(1'h0, `ISA_OFF_BUF, 32'h0);
		chk8(rdat[7:0], 8'h59);
		apb(1'h1, `ISA_OFF_STATUS, 32'h0);
		snd(8'h99, 1'h1, 1'h1);
		apb(1'h0, `ISA_OFF_BUF, 32'h0);
		chk8(rdat[7:0], 8'h99);
		$display("ten bit test done");
	endtask
	// ==========================================
	// Verdict
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		t_reset;
		t_table;
		t_recv;
		t_stretch;
		t_ten;
		end_sim;
	end
endmodule

/* tb/isa_sva.sv */
// Wire checks on the two-wire link, slave end drives only
`timescale 1ns/1ps
module isa_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Resolved lines
	input wire logic scl,
	input wire logic sda,
	// Slave drives
	input wire logic scl_o_s,
	input wire logic scl_oe_s,
	input wire logic sda_o_s,
	input wire logic sda_oe_s
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// ==========================================
	// Steps
	// Ack lasts a whole clock high phase, far past eight cycles
	sequence s_ack_hold;
		sda_oe_s [*8];
	endsequence
	// A stretch outlives any software reaction
	sequence s_clk_hold;
		scl_oe_s [*4];
	endsequence
	// ==========================================
	// Assertions
	a_sda_drive_low: assert property (sda_oe_s |-> !sda_o_s)
		else $error("slave drove data high");
	a_scl_drive_low: assert property (scl_oe_s |-> !scl_o_s)
		else $error("slave drove clock high");
	a_reset_free: assert property ($fell(rst) |-> !sda_oe_s && !scl_oe_s)
		else $error("lines held after reset");
	a_ack_start_low: assert property ($rose(sda_oe_s) |-> !scl)
		else $error("ack began in clock high");
	a_ack_hold_span: assert property ($rose(sda_oe_s) |-> s_ack_hold)
		else $error("ack too short");
	a_ack_end_low: assert property ($fell(sda_oe_s) |-> !scl)
		else $error("ack ended in clock high");
	a_sda_high_quiet: assert property (scl && $past(scl) |-> $stable(sda_oe_s))
		else $error("data moved in clock high");
	a_stretch_low: assert property ($rose(scl_oe_s) |-> !scl)
		else $error("stretch cut a high phase");
	a_stretch_span: assert property ($rose(scl_oe_s) |-> s_clk_hold)
		else $error("stretch too short");
endmodule
